// ---- hw/fus_flash_dev.sv ----
// Flash sequencer: key unlock state machine, control register, array ops
`timescale 1ns/1ns

// Functional notes
// - Keys 0x5A then 0x1F release the flash
// - Wrong or misordered key freezes until reset
// - Control write while released relocks key machine
// - State field: 00 lock,01 half,10 frozen,11 free
// - 0x23 erase, 0x25 preprogram, 0x21 write
// - Software preprograms a page before erasing it
// - Page holding sector 0x7F00~0x7FFF never erased
// - 128 sectors of 256 bytes, 16 pages
// - Page erase lasts between 120 and 150 ms
// - Data write starts armed op while enabled
// - Fail flag bit 4 shows last write or preprogram failure
// - Erase and preprogram act only when enabled
// - Page operations need page enable bit 5
// - Software masks interrupts before self-programming
// - No erase or program unless key released
module fus_flash_dev #(
  parameter int unsigned ERASE_CYCLES = fus_pkg::ERASE_CYC
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       arst_n_i,
  fus_if.dev                              bus,
  output logic                            arr_start_o,
  output logic [1:0]                      arr_op_o,
  output logic [fus_pkg::ADDR_W-1:0]      arr_addr_o,
  output logic [7:0]                      arr_data_o,
  input  wire logic                       arr_done_i,
  input  wire logic                       arr_fail_i
);

  typedef struct packed {
    fus_pkg::fus_key_type       key;
    logic [7:0]                 ctrl;
    logic                       armed;
    fus_pkg::fus_op_type        op;
    logic                       busy;
    logic [fus_pkg::CNT_W-1:0]  cnt;
    logic                       start;
    logic [fus_pkg::ADDR_W-1:0] addr;
    logic [7:0]                 data;
    logic                       done;
  } fus_dev_state_type;

  localparam fus_dev_state_type STATE_RESET = '{
    key:   fus_pkg::KEY_LOCKED,
    ctrl:  fus_pkg::CTRL_RESET,
    armed: 1'b0,
    op:    fus_pkg::OP_NONE,
    busy:  1'b0,
    cnt:   '0,
    start: 1'b0,
    addr:  '0,
    data:  8'h00,
    done:  1'b0
  };

  localparam logic [fus_pkg::CNT_W-1:0] ERASE_LAST =
    fus_pkg::CNT_W'(ERASE_CYCLES - 1);

  fus_dev_state_type q;
  fus_dev_state_type d;

  logic                       key_wr;
  logic                       ctrl_wr;
  logic                       en;
  logic                       ers;
  logic                       pre;
  logic                       page_en;
  logic                       last_page;
  fus_pkg::fus_op_type        req_op;
  logic [fus_pkg::ADDR_W-1:0] page_base;

  assign key_wr  = bus.sfr_wr && (bus.sfr_addr == fus_pkg::SFR_KEY_ADDR);
  assign ctrl_wr = bus.sfr_wr && (bus.sfr_addr == fus_pkg::SFR_CTRL_ADDR);

  assign en      = q.ctrl[fus_pkg::BIT_EN];
  assign ers     = q.ctrl[fus_pkg::BIT_ERS];
  assign pre     = q.ctrl[fus_pkg::BIT_PRE];
  assign page_en = q.ctrl[fus_pkg::BIT_PAGE];

  // Page that contains the protected last sector
  assign last_page = (bus.x_addr[fus_pkg::PAGE_MSB:fus_pkg::PAGE_LSB] ==
                      fus_pkg::LAST_SECTOR[6:3]);

  assign page_base = {bus.x_addr[fus_pkg::PAGE_MSB:fus_pkg::PAGE_LSB],
                      {fus_pkg::PAGE_LSB{1'b0}}};

  // Operation selected by the armed control value
  always_comb begin
    req_op = fus_pkg::OP_NONE;
    if (en) begin
      if (ers) begin
        if (page_en && !last_page) begin
          req_op = fus_pkg::OP_ERASE;
        end
      end else if (pre) begin
        if (page_en) begin
          req_op = fus_pkg::OP_PREPROG;
        end
      end else begin
        req_op = fus_pkg::OP_WRITE;
      end
    end
  end

  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.done  = 1'b0;

    // Key sequence
    if (key_wr) begin
      case (q.key)
        fus_pkg::KEY_LOCKED: begin
          if (bus.sfr_wdata == fus_pkg::KEY_FIRST) begin
            d.key = fus_pkg::KEY_HALF;
          end else begin
            d.key = fus_pkg::KEY_FROZEN;
          end
        end
        fus_pkg::KEY_HALF: begin
          if (bus.sfr_wdata == fus_pkg::KEY_SECOND) begin
            d.key = fus_pkg::KEY_RELEASED;
          end else begin
            d.key = fus_pkg::KEY_FROZEN;
          end
        end
        fus_pkg::KEY_RELEASED: begin
          d.key = fus_pkg::KEY_FROZEN;
        end
        default: begin
          d.key = fus_pkg::KEY_FROZEN;
        end
      endcase
    end

    // Control write; fail flag is kept, reserved bits stay zero
    if (ctrl_wr && !q.busy) begin
      d.ctrl = (bus.sfr_wdata & fus_pkg::CTRL_WMASK) |
               (q.ctrl & ~fus_pkg::CTRL_WMASK);
      d.armed = 1'b0;
      if (q.key == fus_pkg::KEY_RELEASED) begin
        d.key   = fus_pkg::KEY_LOCKED;
        d.armed = 1'b1;
      end
    end else if (ctrl_wr && (q.key == fus_pkg::KEY_RELEASED)) begin
      d.key = fus_pkg::KEY_LOCKED;
    end

    // Data write starts the armed operation once
    if (bus.x_wr && q.armed && !q.busy && (q.key != fus_pkg::KEY_FROZEN)) begin
      d.armed = 1'b0;
      if (req_op != fus_pkg::OP_NONE) begin
        d.busy  = 1'b1;
        d.start = 1'b1;
        d.op    = req_op;
        d.cnt   = '0;
        d.data  = bus.x_wdata;
        if (req_op == fus_pkg::OP_WRITE) begin
          d.addr = bus.x_addr;
        end else begin
          d.addr = page_base;
        end
      end
    end

    // Running operation
    if (q.busy) begin
      if (q.op == fus_pkg::OP_ERASE) begin
        if (q.cnt == ERASE_LAST) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.op   = fus_pkg::OP_NONE;
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end else if (arr_done_i) begin
        d.ctrl[fus_pkg::BIT_FAIL] = arr_fail_i;
        d.busy = 1'b0;
        d.done = 1'b1;
        d.op   = fus_pkg::OP_NONE;
      end
    end

    // Frozen flash never runs an operation again
    if (d.key == fus_pkg::KEY_FROZEN) begin
      d.armed = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign bus.ctrl_rd   = q.ctrl;
  assign bus.key_state = q.key;
  assign bus.busy      = q.busy;
  assign bus.op_done   = q.done;

  assign arr_start_o = q.start;
  assign arr_op_o    = q.op;
  assign arr_addr_o  = q.addr;
  assign arr_data_o  = q.data;

endmodule

// ---- hw/fus_pkg.sv ----
// Shared constants and types of the flash unlock and program sequencer
package fus_pkg;

  // Register addresses seen on the core's special function bus
  localparam logic [7:0] SFR_KEY_ADDR  = 8'h84;
  localparam logic [7:0] SFR_CTRL_ADDR = 8'h85;

  // Unlock key bytes, in order
  localparam logic [7:0] KEY_FIRST  = 8'h5A;
  localparam logic [7:0] KEY_SECOND = 8'h1F;

  // Control register fields
  localparam int         BIT_EN     = 0;
  localparam int         BIT_ERS    = 1;
  localparam int         BIT_PRE    = 2;
  localparam int         BIT_FAIL   = 4;
  localparam int         BIT_PAGE   = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h27;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Array geometry: 128 sectors of 256 bytes, 16 pages of 8 sectors
  localparam int         ADDR_W      = 15;
  localparam int         PAGE_MSB    = 14;
  localparam int         PAGE_LSB    = 11;
  localparam int         PAGES       = 16;
  localparam logic [6:0] LAST_SECTOR = 7'h7F;

  // Page erase time
  localparam int unsigned CLK_KHZ      = 20000;
  localparam int unsigned ERASE_MIN_MS = 120;
  localparam int unsigned ERASE_MAX_MS = 150;
  localparam int unsigned ERASE_CYC    = ERASE_MIN_MS * CLK_KHZ;
  localparam int          CNT_W        = 22;

  typedef enum logic [1:0] {
    KEY_LOCKED   = 2'b00,
    KEY_HALF     = 2'b01,
    KEY_FROZEN   = 2'b10,
    KEY_RELEASED = 2'b11
  } fus_key_type;

  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_WRITE   = 2'b01,
    OP_PREPROG = 2'b10,
    OP_ERASE   = 2'b11
  } fus_op_type;

  // Controller register map on AHB-Lite
  localparam logic [7:0] REG_SFR      = 8'h00;
  localparam logic [7:0] REG_XDATA    = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  localparam int IRQ_DONE    = 0;
  localparam int IRQ_FROZEN  = 1;
  localparam int IRQ_REFUSED = 2;
  localparam int IRQ_W       = 3;

endpackage

// ---- hw/fus_if.sv ----
// Link between the core-side controller and the flash sequencer
`timescale 1ns/1ns
interface fus_if;
  logic                      sfr_wr;
  logic [7:0]                sfr_addr;
  logic [7:0]                sfr_wdata;
  logic                      x_wr;
  logic [fus_pkg::ADDR_W-1:0] x_addr;
  logic [7:0]                x_wdata;
  logic [7:0]                ctrl_rd;
  logic [1:0]                key_state;
  logic                      busy;
  logic                      op_done;

  modport dev (
    input  sfr_wr, sfr_addr, sfr_wdata, x_wr, x_addr, x_wdata,
    output ctrl_rd, key_state, busy, op_done
  );

  modport core (
    output sfr_wr, sfr_addr, sfr_wdata, x_wr, x_addr, x_wdata,
    input  ctrl_rd, key_state, busy, op_done
  );
endinterface

// ---- hw/fus_core_ctl.sv ----
// Core-side controller: AHB-Lite registers driving the sequencer link
`timescale 1ns/1ns
module fus_core_ctl (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic [31:0]      hrdata_o,
  output logic             hresp_o,
  output logic             irq_o,
  fus_if.core              bus
);

  typedef struct packed {
    logic                       ph_wr;
    logic                       ph_rd;
    logic [7:0]                 ph_addr;
    logic                       rd_wait;
    logic [31:0]                rdata;
    logic                       sfr_wr;
    logic [7:0]                 sfr_addr;
    logic [7:0]                 sfr_wdata;
    logic                       x_wr;
    logic [fus_pkg::ADDR_W-1:0] x_addr;
    logic [7:0]                 x_wdata;
    logic [fus_pkg::IRQ_W-1:0]  irq_stat;
    logic [fus_pkg::IRQ_W-1:0]  irq_mask;
    logic [fus_pkg::PAGES-1:0]  prepped;
    logic [1:0]                 key_prev;
  } fus_ctl_state_type;

  fus_ctl_state_type q;
  fus_ctl_state_type d;

  logic                      acc;
  logic                      arm_ers;
  logic                      arm_pre;
  logic [3:0]                page;
  logic [fus_pkg::IRQ_W-1:0] ev;
  logic [fus_pkg::IRQ_W-1:0] clr;

  assign acc = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
  assign arm_ers = bus.ctrl_rd[fus_pkg::BIT_EN] &&
                   bus.ctrl_rd[fus_pkg::BIT_ERS];
  // Page counts as preprogrammed when control shows enable, preprogram and page bits set
  assign arm_pre = bus.ctrl_rd[fus_pkg::BIT_EN] &&
                   bus.ctrl_rd[fus_pkg::BIT_PRE] &&
                   bus.ctrl_rd[fus_pkg::BIT_PAGE];
  assign page = hwdata_i[8+fus_pkg::PAGE_MSB:8+fus_pkg::PAGE_LSB];

  always_comb begin
    d        = q;
    d.sfr_wr = 1'b0;
    d.x_wr   = 1'b0;
    d.key_prev = bus.key_state;
    ev       = '0;
    clr      = '0;
    ev[fus_pkg::IRQ_DONE]   = bus.op_done;
    ev[fus_pkg::IRQ_FROZEN] = (bus.key_state == fus_pkg::KEY_FROZEN) &&
                              (q.key_prev != fus_pkg::KEY_FROZEN);

    if (hready_i) begin
      d.ph_wr   = acc && hwrite_i;
      d.ph_rd   = acc && !hwrite_i;
      d.rd_wait = 1'b0;
      if (acc) begin
        d.ph_addr = haddr_i[7:0];
      end
    end

    // Reads take one wait state so the data comes from a flop
    if (q.ph_rd && !q.rd_wait) begin
      d.rd_wait = 1'b1;
      case (q.ph_addr)
        fus_pkg::REG_STATUS: begin
          d.rdata = {q.prepped, 5'h00, bus.busy, bus.key_state,
                     bus.ctrl_rd};
        end
        fus_pkg::REG_IRQ_STAT: begin
          d.rdata = {29'h0000_0000, q.irq_stat};
          clr     = q.irq_stat;
        end
        fus_pkg::REG_IRQ_MASK: begin
          d.rdata = {29'h0000_0000, q.irq_mask};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (q.ph_wr) begin
      case (q.ph_addr)
        fus_pkg::REG_SFR: begin
          d.sfr_wr    = 1'b1;
          d.sfr_addr  = hwdata_i[15:8];
          d.sfr_wdata = hwdata_i[7:0];
        end
        fus_pkg::REG_XDATA: begin
          if ((|q.irq_mask) || (arm_ers && !q.prepped[page])) begin
            ev[fus_pkg::IRQ_REFUSED] = 1'b1;
          end else begin
            d.x_wr    = 1'b1;
            d.x_addr  = hwdata_i[8+fus_pkg::ADDR_W-1:8];
            d.x_wdata = hwdata_i[7:0];
            if (arm_ers) begin
              d.prepped[page] = 1'b0;
            end else if (arm_pre) begin
              d.prepped[page] = 1'b1;
            end
          end
        end
        fus_pkg::REG_IRQ_MASK: begin
          d.irq_mask = hwdata_i[fus_pkg::IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Set wins over read-clear
    d.irq_stat = (q.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hreadyout_o   = !(q.ph_rd && !q.rd_wait);
  assign hrdata_o      = q.rdata;
  assign hresp_o       = 1'b0;
  assign irq_o         = |(q.irq_stat & q.irq_mask);
  assign bus.sfr_wr    = q.sfr_wr;
  assign bus.sfr_addr  = q.sfr_addr;
  assign bus.sfr_wdata = q.sfr_wdata;
  assign bus.x_wr      = q.x_wr;
  assign bus.x_addr    = q.x_addr;
  assign bus.x_wdata   = q.x_wdata;

endmodule

// ---- verif/fus_link_monitor.sv ----
// Link checker between controller and sequencer
`timescale 1ns/1ns
module fus_link_monitor #(
  parameter int unsigned ERASE_CYCLES = 20
) (
  input wire logic                       ref_clk_i,
  input wire logic                       arst_n_i,
  input wire logic                       sfr_wr,
  input wire logic [7:0]                 sfr_addr,
  input wire logic [7:0]                 sfr_wdata,
  input wire logic                       x_wr,
  input wire logic [fus_pkg::ADDR_W-1:0] x_addr,
  input wire logic [7:0]                 x_wdata,
  input wire logic [7:0]                 ctrl_rd,
  input wire logic [1:0]                 key_state,
  input wire logic                       busy,
  input wire logic                       op_done
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic        key_wr, ctl_wr, bad_key, armed_q, erase_q;
  logic [31:0] run_q;

  assign key_wr  = sfr_wr && sfr_addr == fus_pkg::SFR_KEY_ADDR;
  assign ctl_wr  = sfr_wr && sfr_addr == fus_pkg::SFR_CTRL_ADDR;
  assign bad_key = key_state == 2'b11 ||
    (key_state == 2'b00 && sfr_wdata != fus_pkg::KEY_FIRST) ||
    (key_state == 2'b01 && sfr_wdata != fus_pkg::KEY_SECOND);

  // Busy length, and whether a control write found the key released
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_q   <= 32'h0000_0000;
      armed_q <= 1'b0;
      erase_q <= 1'b0;
    end else begin
      run_q <= busy ? run_q + 32'h0000_0001 : 32'h0000_0000;
      if (ctl_wr)
        armed_q <= key_state == 2'b11;
      if (!busy)
        erase_q <= ctrl_rd[fus_pkg::BIT_ERS] && ctrl_rd[fus_pkg::BIT_EN];
    end
  end

  sequence second_key_s;
    key_wr && sfr_wdata == fus_pkg::KEY_SECOND && key_state == 2'b01;
  endsequence

  property no_start_p(logic cond);
    x_wr && !busy && cond |=> !busy;
  endproperty

  key_release_a: assert property (
    second_key_s |-> ##[1:2] key_state == 2'b11)
    else $error("second key did not release");
  bad_key_a: assert property (
    key_wr && bad_key |-> ##[1:2] key_state == 2'b10)
    else $error("wrong key did not freeze");
  frozen_hold_a: assert property (
    key_state == 2'b10 |=> key_state == 2'b10)
    else $error("frozen state left without reset");
  ctrl_relock_a: assert property (
    ctl_wr && key_state == 2'b11 |-> ##[1:2] key_state == 2'b00)
    else $error("control write did not relock");
  start_cause_a: assert property (
    $rose(busy) |-> $past(x_wr))
    else $error("operation started without data write");
  locked_op_a: assert property (no_start_p(!armed_q))
    else $error("operation started without release");
  frozen_op_a: assert property (no_start_p(key_state == 2'b10))
    else $error("operation started while frozen");
  enable_gate_a: assert property (
    no_start_p(!ctrl_rd[fus_pkg::BIT_EN]))
    else $error("operation started with enable clear");
  page_gate_a: assert property (no_start_p(
    (ctrl_rd[fus_pkg::BIT_ERS] || ctrl_rd[fus_pkg::BIT_PRE]) &&
    !ctrl_rd[fus_pkg::BIT_PAGE])) else $error("page op without page bit");
  last_page_a: assert property (no_start_p(
    ctrl_rd[fus_pkg::BIT_ERS] && x_addr[14:11] == 4'hF))
    else $error("last page erase started");
  erase_time_a: assert property (
    $fell(busy) && erase_q |-> run_q == ERASE_CYCLES)
    else $error("erase length wrong");
  reset_state_a: assert property (
    $rose(arst_n_i) |-> key_state == 2'b00 && ctrl_rd == 8'h00)
    else $error("state not cleared by reset");
endmodule

// ---- verif/testbench.sv ----
// Bench joining controller and sequencer over their link
`timescale 1ns/1ns
module testbench;
  localparam int unsigned ERASE_N = 20;
  logic        ref_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans, arr_op, st_op;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic        arr_start, arr_fail;
  logic        arr_done = 1'b0;
  logic [14:0] arr_addr, st_addr;
  logic [7:0]  arr_data, st_data;
  logic [7:0]  st_cnt = 8'h00;
  int          failures, cmp_count;

  fus_if link ();
  fus_core_ctl fus_core_ctl_inst (.ref_clk_i(ref_clk), .arst_n_i(arst_n),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(hresp),
    .irq_o(irq), .bus(link));
  fus_flash_dev #(.ERASE_CYCLES(ERASE_N)) fus_flash_dev_inst (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .bus(link),
    .arr_start_o(arr_start), .arr_op_o(arr_op), .arr_addr_o(arr_addr),
    .arr_data_o(arr_data), .arr_done_i(arr_done), .arr_fail_i(arr_fail));
  fus_link_monitor #(.ERASE_CYCLES(ERASE_N)) fus_link_monitor_inst (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .sfr_wr(link.sfr_wr),
    .sfr_addr(link.sfr_addr), .sfr_wdata(link.sfr_wdata),
    .x_wr(link.x_wr), .x_addr(link.x_addr), .x_wdata(link.x_wdata),
    .ctrl_rd(link.ctrl_rd), .key_state(link.key_state),
    .busy(link.busy), .op_done(link.op_done));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Array answers each start one cycle later
  always @(posedge ref_clk) begin
    arr_done <= arr_start;
    if (arr_start) begin
      st_cnt  <= st_cnt + 8'h01;
      st_op   <= arr_op;
      st_addr <= arr_addr;
      st_data <= arr_data;
    end
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic limit(input int n);
    if (n >= 400) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic step(inout int n);
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    limit(n);
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    step(n);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    step(n);
    q = hrdata;
    check("response", 32'(hresp), 32'h0000_0000);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic sfr(input logic [7:0] t, input logic [7:0] d);
    xfer(1'b1, fus_pkg::REG_SFR, {16'h0000, t, d});
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic key_is(input logic [1:0] e);
    rd(fus_pkg::REG_STATUS);
    check("key state", 32'(q[9:8]), 32'(e));
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (link.busy !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    limit(n);
  endtask

  task automatic reset_dut();
    arst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
  endtask

  // Flags: array failure, start expected, key frozen
  task automatic run_op(input logic [7:0] c, input logic [14:0] a,
                        input logic [2:0] f, input logic [1:0] eop,
                        input logic [14:0] ea);
    logic [7:0] n0;
    n0 = st_cnt;
    arr_fail <= f[2];
    sfr(fus_pkg::SFR_KEY_ADDR, fus_pkg::KEY_FIRST);
    key_is(f[0] ? 2'b10 : 2'b01);
    sfr(fus_pkg::SFR_KEY_ADDR, fus_pkg::KEY_SECOND);
    key_is(f[0] ? 2'b10 : 2'b11);
    sfr(fus_pkg::SFR_CTRL_ADDR, c);
    key_is(f[0] ? 2'b10 : 2'b00);
    xfer(1'b1, fus_pkg::REG_XDATA, {9'h000, a, 8'hC3});
    repeat (3) @(posedge ref_clk);
    wait_idle();
    check("start count", 32'(st_cnt - n0), 32'(f[1]));
    if (f[1]) begin
      rd(fus_pkg::REG_STATUS);
      check("array op", 32'(st_op), 32'(eop));
      check("array addr", 32'(st_addr), 32'(ea));
      if (eop != fus_pkg::OP_ERASE)
        check("fail flag", 32'(q[4]), 32'(f[2]));
      if (eop != fus_pkg::OP_WRITE)
        check("page map", 32'(q[16 + ea[14:11]]), 32'(!eop[0]));
      else
        check("array data", 32'(st_data), 32'h0000_00C3);
    end
  endtask

  initial begin
    arst_n   = 1'b0;
    hsel     = 1'b0;
    haddr    = 32'h0000_0000;
    htrans   = 2'b00;
    hwrite   = 1'b0;
    hwdata   = 32'h0000_0000;
    arr_fail = 1'b0;
    reset_dut();
    rd(fus_pkg::REG_STATUS);
    check("reset status", q, 32'h0000_0000);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14);
    check("unmapped", q, 32'h0000_0000);
    run_op(8'h25, 15'h1234, 3'b010, 2'b10, 15'h1000);
    run_op(8'h23, 15'h17FF, 3'b010, 2'b11, 15'h1000);
    run_op(8'h21, 15'h7F05, 3'b110, 2'b01, 15'h7F05);
    run_op(8'h21, 15'h0002, 3'b010, 2'b01, 15'h0002);
    run_op(8'h25, 15'h7F00, 3'b010, 2'b10, 15'h7800);
    rd(fus_pkg::REG_IRQ_STAT);
    check("irq status", q, 32'h0000_0001);
    check("irq masked", 32'(irq), 32'h0000_0000);
    rd(fus_pkg::REG_IRQ_STAT);
    check("irq cleared", q, 32'h0000_0000);
    run_op(8'h23, 15'h7FFF, 3'b000, 2'b11, 15'h7800);
    run_op(8'h24, 15'h0800, 3'b000, 2'b10, 15'h0800);
    run_op(8'h05, 15'h0800, 3'b000, 2'b10, 15'h0800);
    run_op(8'h23, 15'h0800, 3'b000, 2'b11, 15'h0800);
    rd(fus_pkg::REG_IRQ_STAT);
    check("refused flag", q, 32'h0000_0004);
    xfer(1'b1, fus_pkg::REG_IRQ_MASK, 32'h0000_0007);
    rd(fus_pkg::REG_IRQ_MASK);
    check("irq mask", q, 32'h0000_0007);
    run_op(8'h21, 15'h0100, 3'b000, 2'b01, 15'h0100);
    check("irq raised", 32'(irq), 32'h0000_0001);
    rd(fus_pkg::REG_IRQ_STAT);
    repeat (2) @(posedge ref_clk);
    check("irq dropped", 32'(irq), 32'h0000_0000);
    xfer(1'b1, fus_pkg::REG_IRQ_MASK, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      reset_dut();
      if (i == 1)
        sfr(fus_pkg::SFR_KEY_ADDR, fus_pkg::KEY_FIRST);
      sfr(fus_pkg::SFR_KEY_ADDR, i == 0 ? fus_pkg::KEY_SECOND : 8'h77);
      key_is(2'b10);
      run_op(8'h21, 15'h0100, 3'b001, 2'b01, 15'h0100);
      rd(fus_pkg::REG_IRQ_STAT);
      check("frozen flag", 32'(q[1]), 32'h0000_0001);
    end
    reset_dut();
    rd(fus_pkg::REG_STATUS);
    check("second reset", q, 32'h0000_0000);
    finish_test();
  end
endmodule
